// ---- design/lrf_pkg.sv ----
// Operation
// - packet is A, attribute, length, data, dollar
// - attribute chars 1 to 5 by packet type
// - notice packets carry one space byte
// - record count is two digits, MSD first
// - all values sent as ASCII digits, MSD first
// - time field is ten decimal digits
// - illuminance four digits, clamped to 1000 in records outside raw mode
// - temperature four digits in hundredths, max 9999
// - slash between records, comma between fields
// - all-data: count then full min/avg/max records; the code sends each channel as avg, min, max
// - current data: time, ch0, ch1 comma separated
// - raw mode: ch0/ch1 unconverted in four digits
// - raw mode threshold configurable, default 2500
// - fast option: 1 s acquire, 1 min process
// - mode indicator high only in run mode
// - clock monitor toggles except in standby
// - manual wake cancels low power, indicator blinks
package lrf_pkg;
    localparam logic [7:0] CH_START     = 8'h41;
    localparam logic [7:0] CH_END       = 8'h24;
    localparam logic [7:0] CH_SLASH     = 8'h2f;
    localparam logic [7:0] CH_COMMA     = 8'h2c;
    localparam logic [7:0] CH_SPACE     = 8'h20;
    localparam logic [7:0] CH_ZERO      = 8'h30;
    localparam logic [7:0] CH_NINE      = 8'h39;
    localparam logic [7:0] CH_ATTR_BASE = 8'h31;
    localparam int VAL_W  = 14;
    localparam int TIME_W = 32;
    localparam int CNV_W  = 34;
    localparam int BCD_W  = 40;
    localparam int REC_W  = 7;
    localparam int TMR_W  = 40;
    localparam logic [3:0] LEN_DIGITS   = 4'h4;
    localparam logic [3:0] CNT_DIGITS   = 4'h2;
    localparam logic [3:0] TIME_DIGITS  = 4'ha;
    localparam logic [3:0] FIELD_DIGITS = 4'h4;
    localparam logic [13:0] LEN_NOTICE  = 14'h0001;
    localparam logic [13:0] LEN_CUR     = 14'h0014;
    localparam logic [13:0] LEN_HEAD    = 14'h0002;
    localparam logic [13:0] LEN_REC_ALL = 14'h0029;
    localparam logic [13:0] LEN_REC_AVG = 14'h0015;
    localparam logic [REC_W-1:0] CNT_MAX = 7'h63;
    localparam logic [VAL_W-1:0] LUX_MAX     = 14'h03e8;
    localparam logic [VAL_W-1:0] FIELD_MAX   = 14'h270f;
    localparam logic [VAL_W-1:0] LUX_THRESH  = 14'h0258;
    localparam logic [VAL_W-1:0] TEMP_THRESH = 14'h0bb8;
    localparam logic [VAL_W-1:0] RAW_THRESH  = 14'h09c4;
    localparam longint CLK_HZ        = 125_000_000;
    localparam longint ACQ_NORMAL_S  = 60;
    localparam longint PROC_NORMAL_S = 3600;
    localparam longint ACQ_FAST_S    = 1;
    localparam longint PROC_FAST_S   = 60;
    localparam longint BLINK_HALF_MS = 125;
    localparam longint ACQ_NORMAL_CYC  = ACQ_NORMAL_S * CLK_HZ;
    localparam longint PROC_NORMAL_CYC = PROC_NORMAL_S * CLK_HZ;
    localparam longint ACQ_FAST_CYC    = ACQ_FAST_S * CLK_HZ;
    localparam longint PROC_FAST_CYC   = PROC_FAST_S * CLK_HZ;
    localparam longint BLINK_HALF_CYC  = BLINK_HALF_MS * CLK_HZ / 1000;
    localparam logic [3:0] BLINK_TOGGLES = 4'h6;
    localparam logic [5:0] CONV_STEPS    = 6'h22;

    typedef enum logic [2:0] {
        ATTR_AVG, ATTR_ALL, ATTR_CUR, ATTR_WAKE, ATTR_ERR
    } lrf_attr_t;
    typedef enum logic [1:0] {PM_RUN, PM_STANDBY, PM_SNOOZE} lrf_pmode_t;
    typedef enum logic [3:0] {
        P_START, P_ATTR, P_LEN, P_SPACE, P_COUNT, P_SLASH,
        P_TIME, P_SEP, P_FIELD, P_END
    } lrf_phase_t;
    typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_WAIT, ST_EMIT} lrf_state_t;
endpackage

// ---- design/lrf_conv_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface lrf_conv_if;
    import lrf_pkg::*;
    logic             start;
    logic [CNV_W-1:0] value;
    logic             done;
    logic [BCD_W-1:0] bcd;
    modport master (output start, output value, input done, input bcd);
    modport slave  (input start, input value, output done, output bcd);
endinterface
`default_nettype wire

// ---- design/lrf_dec_conv.sv ----
`timescale 1ns/1ps
`default_nettype none
// binary to ten packed decimal digits, one bit per clock
module lrf_dec_conv (
    input  wire logic core_clk,   // system clock
    input  wire logic sys_rst,    // async reset, high
    lrf_conv_if.slave cv          // conversion request
);
    import lrf_pkg::*;
    logic [CNV_W-1:0] shift_ff;
    logic [BCD_W-1:0] bcd_ff;
    logic [BCD_W-1:0] adj;
    logic [5:0]       cnt_ff;
    logic             busy_ff;
    logic             done_ff;

    genvar i;
    generate
        for (i = 0; i < BCD_W / 4; i++) begin : g_adj
            assign adj[i*4 +: 4] = (bcd_ff[i*4 +: 4] >= 4'h5) ?
                bcd_ff[i*4 +: 4] + 4'h3 : bcd_ff[i*4 +: 4];
        end
    endgenerate

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            shift_ff <= '0;
            bcd_ff   <= '0;
            cnt_ff   <= '0;
            busy_ff  <= 1'b0;
            done_ff  <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (cv.start && !busy_ff) begin
                shift_ff <= cv.value;
                bcd_ff   <= '0;
                cnt_ff   <= CONV_STEPS;
                busy_ff  <= 1'b1;
            end else if (busy_ff) begin
                bcd_ff   <= {adj[BCD_W-2:0], shift_ff[CNV_W-1]};
                shift_ff <= {shift_ff[CNV_W-2:0], 1'b0};
                cnt_ff   <= cnt_ff - 6'h1;
                if (cnt_ff == 6'h1) begin
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                end
            end
        end
    end

    assign cv.done = done_ff;
    assign cv.bcd  = bcd_ff;

    a_conv_latency: assert property (@(posedge core_clk) disable iff (sys_rst)
        cv.start && !busy_ff |-> ##35 done_ff)
        else $error("conversion did not finish in 35 cycles");
endmodule
`default_nettype wire

// ---- design/logger_response_formatter.sv ----
`timescale 1ns/1ps
`default_nettype none
module logger_response_formatter #(
    parameter longint ACQ_NORMAL  = lrf_pkg::ACQ_NORMAL_CYC,
    parameter longint PROC_NORMAL = lrf_pkg::PROC_NORMAL_CYC,
    parameter longint ACQ_FAST    = lrf_pkg::ACQ_FAST_CYC,
    parameter longint PROC_FAST   = lrf_pkg::PROC_FAST_CYC,
    parameter longint BLINK_HALF  = lrf_pkg::BLINK_HALF_CYC,
    parameter logic [lrf_pkg::VAL_W-1:0] RAW_THR = lrf_pkg::RAW_THRESH
) (
    input  wire logic                       core_clk,      // clock
    input  wire logic                       sys_rst,       // reset
    input  wire logic                       req_valid,     // packet request
    input  wire lrf_pkg::lrf_attr_t         req_attr,      // packet type
    output logic                            req_ready,     // idle
    input  wire logic [lrf_pkg::REC_W-1:0]  rec_count,     // records held
    output logic [lrf_pkg::REC_W-1:0]       rec_idx,       // record fetched
    input  wire logic [lrf_pkg::TIME_W-1:0] rec_time,      // record time
    input  wire logic [lrf_pkg::VAL_W-1:0]  rec_lux_avg,   // ch0 average
    input  wire logic [lrf_pkg::VAL_W-1:0]  rec_lux_min,   // ch0 minimum
    input  wire logic [lrf_pkg::VAL_W-1:0]  rec_lux_max,   // ch0 maximum
    input  wire logic [lrf_pkg::VAL_W-1:0]  rec_tmp_avg,   // ch1 average
    input  wire logic [lrf_pkg::VAL_W-1:0]  rec_tmp_min,   // ch1 minimum
    input  wire logic [lrf_pkg::VAL_W-1:0]  rec_tmp_max,   // ch1 maximum
    input  wire logic [lrf_pkg::TIME_W-1:0] cur_time,      // present time
    input  wire logic [lrf_pkg::VAL_W-1:0]  cur_ch0,       // present ch0
    input  wire logic [lrf_pkg::VAL_W-1:0]  cur_ch1,       // present ch1
    output logic [7:0]                      tx_data,       // byte out
    output logic                            tx_valid,      // byte valid
    input  wire logic                       tx_ready,      // uart takes
    input  wire logic                       raw_converter_option, // pin
    input  wire logic                       fast_cycle_option,    // pin
    input  wire lrf_pkg::lrf_pmode_t        power_mode,    // power state
    input  wire logic                       manual_wake_input, // pin
    output logic                            low_power_cancel,  // pulse
    output logic                            manual_wake_indicator, // blink
    output logic                            run_mode_indicator, // run
    output logic                            clock_monitor_out,  // toggles
    output logic                            level_ch0,     // ch0 >= thr
    output logic                            level_ch1,     // ch1 >= thr
    output logic                            acquire_tick,  // sample pulse
    output logic                            process_tick   // process pulse
);
    import lrf_pkg::*;

    lrf_conv_if cv ();
    lrf_dec_conv u_conv (.core_clk(core_clk), .sys_rst(sys_rst), .cv(cv));

    lrf_state_t       st_ff;
    lrf_phase_t       phase_ff, nxt_phase;
    lrf_attr_t        attr_ff;
    logic [REC_W-1:0] cnt_ff, rec_ff, nxt_rec;
    logic [2:0]       field_ff, nxt_field, last_field;
    logic [3:0]       left_ff, ndig;
    logic [7:0]       byte_ff, char_now;
    logic [BCD_W-1:0] bcd_ff;
    logic             is_num;
    logic [13:0]      len_val;
    logic [VAL_W-1:0] fval;
    logic [1:0]       raw_s_ff, fast_s_ff, wake_s_ff;
    logic             wake_d_ff;

    // option pins and the wake switch are asynchronous
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            raw_s_ff  <= '0;
            fast_s_ff <= '0;
            wake_s_ff <= '0;
            wake_d_ff <= 1'b0;
        end else begin
            raw_s_ff  <= {raw_s_ff[0], raw_converter_option};
            fast_s_ff <= {fast_s_ff[0], fast_cycle_option};
            wake_s_ff <= {wake_s_ff[0], manual_wake_input};
            wake_d_ff <= wake_s_ff[1];
        end
    end

    function automatic logic [7:0] dig(input logic [BCD_W-1:0] b,
                                       input logic [3:0] idx);
        dig = CH_ZERO | {4'h0, b[int'(idx)*4 +: 4]};
    endfunction

    always_comb begin
        unique case (attr_ff)
            ATTR_ALL:  len_val = LEN_HEAD + 14'(cnt_ff) * LEN_REC_ALL;
            ATTR_AVG:  len_val = LEN_HEAD + 14'(cnt_ff) * LEN_REC_AVG;
            ATTR_CUR:  len_val = LEN_CUR;
            default:   len_val = LEN_NOTICE;
        endcase
        last_field = (attr_ff == ATTR_ALL) ? 3'h5 : 3'h1;
        // raw mode skips the illuminance range limit
        if (attr_ff == ATTR_CUR)
            fval = field_ff == 3'h0 ? cur_ch0 : cur_ch1;
        else if (attr_ff == ATTR_AVG)
            fval = field_ff == 3'h0 ? rec_lux_avg : rec_tmp_avg;
        else begin
            unique case (field_ff)
                3'h0:    fval = rec_lux_avg;
                3'h1:    fval = rec_lux_min;
                3'h2:    fval = rec_lux_max;
                3'h3:    fval = rec_tmp_avg;
                3'h4:    fval = rec_tmp_min;
                default: fval = rec_tmp_max;
            endcase
        end
        if (!raw_s_ff[1] && attr_ff != ATTR_CUR && fval > LUX_MAX
            && (attr_ff == ATTR_AVG ? field_ff == 3'h0 : field_ff < 3'h3))
            fval = LUX_MAX;
        if (fval > FIELD_MAX)
            fval = FIELD_MAX;
        is_num  = 1'b1;
        ndig    = FIELD_DIGITS;
        char_now = CH_END;
        cv.value = CNV_W'(fval);
        unique case (phase_ff)
            P_START: begin is_num = 1'b0; char_now = CH_START; end
            P_ATTR: begin
                is_num = 1'b0;
                char_now = CH_ATTR_BASE + {5'h0, attr_ff};
            end
            P_LEN: begin
                ndig = LEN_DIGITS;
                cv.value = CNV_W'(len_val);
            end
            P_SPACE: begin is_num = 1'b0; char_now = CH_SPACE; end
            P_COUNT: begin
                ndig = CNT_DIGITS;
                cv.value = CNV_W'(cnt_ff);
            end
            P_SLASH: begin is_num = 1'b0; char_now = CH_SLASH; end
            P_TIME: begin
                ndig = TIME_DIGITS;
                cv.value = CNV_W'(attr_ff == ATTR_CUR ? cur_time : rec_time);
            end
            P_SEP: begin is_num = 1'b0; char_now = CH_COMMA; end
            P_FIELD: ;
            P_END: is_num = 1'b0;
        endcase
        nxt_phase = P_END;
        nxt_field = field_ff;
        nxt_rec   = rec_ff;
        unique case (phase_ff)
            P_START: nxt_phase = P_ATTR;
            P_ATTR:  nxt_phase = P_LEN;
            P_LEN: begin
                if (attr_ff == ATTR_CUR)      nxt_phase = P_TIME;
                else if (attr_ff == ATTR_ALL || attr_ff == ATTR_AVG)
                    nxt_phase = P_COUNT;
                else                          nxt_phase = P_SPACE;
            end
            P_COUNT: nxt_phase = (cnt_ff != '0) ? P_SLASH : P_END;
            P_SLASH: nxt_phase = P_TIME;
            P_TIME: begin nxt_phase = P_SEP; nxt_field = 3'h0; end
            P_SEP:   nxt_phase = P_FIELD;
            P_FIELD: begin
                if (field_ff != last_field) begin
                    nxt_phase = P_SEP;
                    nxt_field = field_ff + 3'h1;
                end else if (attr_ff != ATTR_CUR
                             && rec_ff + 7'h1 < cnt_ff) begin
                    nxt_phase = P_SLASH;
                    nxt_rec   = rec_ff + 7'h1;
                end
            end
            default: nxt_phase = P_END;
        endcase
    end

    assign cv.start  = (st_ff == ST_LOAD) && is_num;
    assign req_ready = (st_ff == ST_IDLE);
    assign tx_valid  = (st_ff == ST_EMIT);
    assign tx_data   = byte_ff;
    assign rec_idx   = rec_ff;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff    <= ST_IDLE;
            phase_ff <= P_START;
            attr_ff  <= ATTR_WAKE;
            cnt_ff   <= '0;
            rec_ff   <= '0;
            field_ff <= '0;
            left_ff  <= '0;
            byte_ff  <= '0;
            bcd_ff   <= '0;
        end else begin
            unique case (st_ff)
                ST_IDLE: if (req_valid) begin
                    attr_ff  <= req_attr;
                    cnt_ff   <= rec_count > CNT_MAX ? CNT_MAX : rec_count;
                    rec_ff   <= '0;
                    phase_ff <= P_START;
                    st_ff    <= ST_LOAD;
                end
                ST_LOAD: if (is_num) st_ff <= ST_WAIT;
                else begin
                    byte_ff <= char_now;
                    left_ff <= 4'h1;
                    st_ff   <= ST_EMIT;
                end
                ST_WAIT: if (cv.done) begin
                    bcd_ff  <= cv.bcd;
                    left_ff <= ndig;
                    byte_ff <= dig(cv.bcd, ndig - 4'h1);
                    st_ff   <= ST_EMIT;
                end
                ST_EMIT: if (tx_ready) begin
                    if (left_ff > 4'h1) begin
                        left_ff <= left_ff - 4'h1;
                        byte_ff <= dig(bcd_ff, left_ff - 4'h2);
                    end else begin
                        phase_ff <= nxt_phase;
                        field_ff <= nxt_field;
                        rec_ff   <= nxt_rec;
                        st_ff    <= phase_ff == P_END ? ST_IDLE : ST_LOAD;
                    end
                end
            endcase
        end
    end

    // acquisition and processing periods
    logic [TMR_W-1:0] tmr_ff [2];
    logic [1:0]       tick_ff;
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_tmr
            logic [TMR_W-1:0] per;
            assign per = fast_s_ff[1] ?
                TMR_W'(g == 0 ? ACQ_FAST : PROC_FAST) :
                TMR_W'(g == 0 ? ACQ_NORMAL : PROC_NORMAL);
            always_ff @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    tmr_ff[g]  <= '0;
                    tick_ff[g] <= 1'b0;
                end else begin
                    tick_ff[g] <= tmr_ff[g] >= per - TMR_W'(1);
                    tmr_ff[g]  <= tmr_ff[g] >= per - TMR_W'(1) ?
                                  '0 : tmr_ff[g] + TMR_W'(1);
                end
            end
        end
    endgenerate
    assign acquire_tick = tick_ff[0];
    assign process_tick = tick_ff[1];

    // level judgement and power status pins
    logic [TMR_W-1:0] blink_cnt_ff;
    logic [3:0]       blink_left_ff;
    logic             cancel_ff, blink_ff, run_ff, clkmon_ff, lv0_ff, lv1_ff;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lv0_ff    <= 1'b0;
            lv1_ff    <= 1'b0;
            run_ff    <= 1'b0;
            clkmon_ff <= 1'b0;
        end else begin
            lv0_ff <= cur_ch0 >= (raw_s_ff[1] ? RAW_THR : LUX_THRESH);
            lv1_ff <= cur_ch1 >= (raw_s_ff[1] ? RAW_THR : TEMP_THRESH);
            run_ff <= power_mode == PM_RUN;
            if (power_mode != PM_STANDBY)
                clkmon_ff <= !clkmon_ff;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cancel_ff     <= 1'b0;
            blink_ff      <= 1'b0;
            blink_left_ff <= '0;
            blink_cnt_ff  <= '0;
        end else begin
            cancel_ff <= wake_s_ff[1] && !wake_d_ff;
            if (wake_s_ff[1] && !wake_d_ff) begin
                blink_left_ff <= BLINK_TOGGLES;
                blink_cnt_ff  <= '0;
                blink_ff      <= 1'b1;
            end else if (blink_left_ff != '0) begin
                if (blink_cnt_ff >= TMR_W'(BLINK_HALF) - TMR_W'(1)) begin
                    blink_cnt_ff  <= '0;
                    blink_left_ff <= blink_left_ff - 4'h1;
                    blink_ff      <= blink_left_ff > 4'h1 ? !blink_ff : 1'b0;
                end else
                    blink_cnt_ff <= blink_cnt_ff + TMR_W'(1);
            end
        end
    end
    assign low_power_cancel      = cancel_ff;
    assign manual_wake_indicator = blink_ff;
    assign run_mode_indicator    = run_ff;
    assign clock_monitor_out     = clkmon_ff;
    assign level_ch0             = lv0_ff;
    assign level_ch1             = lv1_ff;

    sequence s_taken;
        tx_valid && tx_ready;
    endsequence
    a_start_char: assert property (@(posedge core_clk) disable iff (sys_rst)
        tx_valid && phase_ff == P_START |-> tx_data == CH_START)
        else $error("packet does not open with start char");
    a_end_char: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_taken ##0 phase_ff == P_END |=> st_ff == ST_IDLE)
        else $error("end char not last");
    a_attr_char: assert property (@(posedge core_clk) disable iff (sys_rst)
        tx_valid && phase_ff == P_ATTR
        |-> tx_data == CH_ATTR_BASE + {5'h0, attr_ff})
        else $error("wrong attribute char");
    a_space_body: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_taken ##0 phase_ff == P_SPACE |=> phase_ff == P_END)
        else $error("notice body longer than one byte");
    a_digit_only: assert property (@(posedge core_clk) disable iff (sys_rst)
        tx_valid && (phase_ff inside {P_LEN, P_COUNT, P_TIME, P_FIELD})
        |-> tx_data >= CH_ZERO && tx_data <= CH_NINE)
        else $error("non digit byte in number");
    a_count_two: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_taken ##0 phase_ff == P_COUNT && left_ff == 4'h2
        |=> phase_ff == P_COUNT)
        else $error("count left too early");
    a_sep_comma: assert property (@(posedge core_clk) disable iff (sys_rst)
        tx_valid && phase_ff == P_SEP |-> tx_data == CH_COMMA)
        else $error("field separator not comma");
    // sampled reset keeps the release edge, where state is still held, out
    a_run_led: assert property (@(posedge core_clk) disable iff (sys_rst)
        !sys_rst
        |=> run_mode_indicator == ($past(power_mode) == PM_RUN))
        else $error("mode indicator wrong");
    a_clk_toggle: assert property (@(posedge core_clk) disable iff (sys_rst)
        !sys_rst && power_mode != PM_STANDBY |=> clock_monitor_out
        != $past(clock_monitor_out))
        else $error("clock monitor not toggling");
    a_clk_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
        power_mode == PM_STANDBY |=> $stable(clock_monitor_out))
        else $error("clock monitor moved in standby");
    a_wake_cancel: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(manual_wake_input) |-> ##[3:4] low_power_cancel
        ##1 manual_wake_indicator)
        else $error("manual wake not seen");
endmodule
`default_nettype wire

// ---- test/lrf_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// byte sink standing in for the serial link toward the host
module lrf_host_model (
    input  wire logic       core_clk, // clock
    input  wire logic       sys_rst,  // reset
    input  wire logic [7:0] tx_data,  // offered byte
    input  wire logic       tx_valid, // byte offered
    input  wire logic       slow,     // take only every other cycle
    output logic            tx_ready, // byte taken
    output logic [7:0]      rx_byte,  // tx_data of last cycle, a taken byte when rx_stb
    output logic            rx_stb    // one-cycle take pulse
);
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_ready <= 1'b0;
            rx_stb   <= 1'b0;
            rx_byte  <= 8'h00;
        end else begin
            tx_ready <= slow ? ~tx_ready : 1'b1;
            rx_stb   <= tx_valid & tx_ready;
            rx_byte  <= tx_data;
        end
    end
endmodule
`default_nettype wire

// ---- test/logger_response_formatter_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module logger_response_formatter_tb;
    import lrf_pkg::*;
    logic core_clk, sys_rst, req_valid, req_ready, tx_valid, tx_ready, b;
    logic raw_converter_option, fast_cycle_option, manual_wake_input;
    logic low_power_cancel, manual_wake_indicator, run_mode_indicator;
    logic clock_monitor_out, level_ch0, level_ch1, acquire_tick;
    logic process_tick, slow, rx_stb;
    lrf_attr_t req_attr;
    lrf_pmode_t power_mode;
    logic [REC_W-1:0] rec_count, rec_idx;
    logic [TIME_W-1:0] rec_time, cur_time;
    logic [VAL_W-1:0] rec_lux_avg, rec_lux_min, rec_lux_max, rec_tmp_avg;
    logic [VAL_W-1:0] rec_tmp_min, rec_tmp_max, cur_ch0, cur_ch1;
    logic [7:0] tx_data, rx_byte;
    logic [7:0] rxq[$];
    int n_mismatch = 0, check_count = 0, cyc = 0, n;

    logger_response_formatter #(.ACQ_NORMAL(20), .PROC_NORMAL(40),
        .ACQ_FAST(5), .PROC_FAST(10), .BLINK_HALF(4))
        u_logger_response_formatter (.*);
    lrf_host_model u_lrf_host_model (.*);

    // record fields follow rec_idx combinationally
    assign rec_time    = 32'hee6b2800 + 32'(rec_idx);
    assign rec_lux_avg = 14'h000c + 14'(rec_idx);
    assign rec_lux_min = 14'h0003;
    assign rec_lux_max = 14'h05dc;
    assign rec_tmp_avg = 14'h0b18;
    assign rec_tmp_min = 14'h03e7;
    assign rec_tmp_max = 14'h270f;

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cyc++;
        if (rx_stb) rxq.push_back(rx_byte);
        if (cyc == 30000) begin
            n_mismatch++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic pkt(input lrf_attr_t a, input string s);
        rxq.delete();
        @(posedge core_clk);
        req_valid <= 1'b1;
        req_attr  <= a;
        @(posedge core_clk);
        req_valid <= 1'b0;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (!(rxq.size() >= s.len() && req_ready === 1'b1) && n < 5000);
        for (int i = 0; i < s.len(); i++)
            chk(i < rxq.size() ? rxq[i] : 8'h00, 32'(s[i]));
        chk(rxq.size(), s.len());
    endtask

    // lux maximum of each record is 1500, clamped outside raw mode
    function automatic string rec(int i, bit all, bit raw);
        longint t;
        t = 64'd4000000000 + i;
        if (!all) return $sformatf("/%010d,%04d,2840", t, 12 + i);
        return $sformatf("/%010d,%04d,0003,%04d,2840,0999,9999", t, 12 + i,
                         raw ? 1500 : 1000);
    endfunction

    task automatic pm(input lrf_pmode_t m, input logic r, input logic t);
        @(posedge core_clk);
        power_mode <= m;
        repeat (3) @(negedge core_clk);
        b = clock_monitor_out;
        @(negedge core_clk);
        chk({run_mode_indicator, clock_monitor_out}, {r, b ^ t});
    endtask

    // cycles between two successive ticks of one kind
    task automatic gap(input bit p, input int exp);
        do @(negedge core_clk); while ((p ? process_tick : acquire_tick) !== 1);
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while ((p ? process_tick : acquire_tick) !== 1'b1 && n < 200);
        chk(n, exp);
    endtask

    task automatic finish_test();
        $display("mismatches=%0d checks=%0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        sys_rst = 1'b1;
        req_valid = 1'b0;
        req_attr = ATTR_AVG;
        rec_count = 7'h00;
        cur_time = 32'h000004d2;
        cur_ch0 = 14'h05dc;
        cur_ch1 = 14'h0b18;
        slow = 1'b0;
        raw_converter_option = 1'b0;
        fast_cycle_option = 1'b0;
        power_mode = PM_RUN;
        manual_wake_input = 1'b0;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        pkt(ATTR_WAKE, "A40001 $");
        pkt(ATTR_ERR, "A50001 $");
        pkt(ATTR_CUR, "A300200000001234,1500,2840$");
        pkt(ATTR_ALL, "A2000200$");
        @(posedge core_clk);
        rec_count <= 7'h02;
        slow <= 1'b1;
        pkt(ATTR_ALL, {"A2008402", rec(0,1,0), rec(1,1,0), "$"});
        pkt(ATTR_AVG, {"A1004402", rec(0,0,0), rec(1,0,0), "$"});
        chk({level_ch0, level_ch1}, 2'b10);
        @(posedge core_clk);
        raw_converter_option <= 1'b1;
        cur_ch1 <= 14'h09c4;
        rec_count <= 7'h01;
        repeat (6) @(negedge core_clk);
        chk({level_ch0, level_ch1}, 2'b01);
        pkt(ATTR_ALL, {"A2004301", rec(0,1,1), "$"});
        pm(PM_STANDBY, 1'b0, 1'b0);
        pm(PM_SNOOZE, 1'b0, 1'b1);
        pm(PM_RUN, 1'b1, 1'b1);
        @(posedge core_clk);
        manual_wake_input <= 1'b1;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (low_power_cancel !== 1'b1 && n < 10);
        chk(low_power_cancel, 1'b1);
        @(negedge core_clk);
        chk(manual_wake_indicator, 1'b1);
        gap(1'b0, 20);
        @(posedge core_clk);
        fast_cycle_option <= 1'b1;
        repeat (30) @(negedge core_clk);
        gap(1'b0, 5);
        gap(1'b1, 10);
        finish_test();
    end
endmodule
`default_nettype wire
